// [include/pdir_map.svh]
/*
  Address map and reset values for the eight-port direction and data register block.
  Assumes a 16-bit byte address from the CPU internal bus.
*/
// Overview of operation
// - Reads of any direction register return all ones regardless of stored value.
// - A direction bit of 0 makes the matching pin an input.
// - A direction bit of 1 makes the pin an output; 0 to 1 switches it.
// - Each data register shares its address with the pin-or-latch read of that port.
// - Data registers sit at fixed addresses FFD4 to FFDD, port 1 to port A.
// - Direction registers sit at fixed addresses FFE4 to FFED, port 1 to port A.
// - Data reads return pin level for inputs and latch bit for outputs.
// - Output pins drive high for latch bit 1 and low for 0.
`ifndef PDIR_MAP_SVH
`define PDIR_MAP_SVH
`define PDIR_DATA_P1 16'hFFD4
`define PDIR_DATA_P3 16'hFFD6
`define PDIR_DATA_P4 16'hFFD7
`define PDIR_DATA_P5 16'hFFD8
`define PDIR_DATA_P6 16'hFFD9
`define PDIR_DATA_P7 16'hFFDA
`define PDIR_DATA_P8 16'hFFDB
`define PDIR_DATA_PA 16'hFFDD
`define PDIR_DIR_P1 16'hFFE4
`define PDIR_DIR_P3 16'hFFE6
`define PDIR_DIR_P4 16'hFFE7
`define PDIR_DIR_P5 16'hFFE8
`define PDIR_DIR_P6 16'hFFE9
`define PDIR_DIR_P7 16'hFFEA
`define PDIR_DIR_P8 16'hFFEB
`define PDIR_DIR_PA 16'hFFED
`define PDIR_DIR_READ 8'hFF
`define PDIR_RESET 8'h00
`endif

// [include/pdir_pkg.sv]
/*
  Types shared by the port direction and data register block.
  Assumes nothing of its surroundings.
*/
package pdir_pkg;
  typedef logic [7:0] pdir_byte_t;
  typedef logic [15:0] pdir_addr_t;
endpackage

// [rtl/pdir_ports.sv]
/*
  Eight 8-bit ports, each with a write-only direction register and a data latch.
  Assumes a single-cycle CPU bus: byte address, read and write strobes on mclk.
*/
`timescale 1ns/1ns
`include "pdir_map.svh"
module pdir_ports #(
  parameter int NPORT = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire pdir_pkg::pdir_addr_t bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire pdir_pkg::pdir_byte_t bus_wdata,
  output pdir_pkg::pdir_byte_t bus_rdata,
  output logic bus_hit,
  input wire logic [NPORT*8-1:0] pin_in,
  output logic [NPORT*8-1:0] pin_out,
  output logic [NPORT*8-1:0] pin_oe_n
);
  localparam pdir_pkg::pdir_addr_t DATA_ADDR [8] = '{`PDIR_DATA_P1, `PDIR_DATA_P3,
    `PDIR_DATA_P4, `PDIR_DATA_P5, `PDIR_DATA_P6, `PDIR_DATA_P7, `PDIR_DATA_P8,
    `PDIR_DATA_PA};
  localparam pdir_pkg::pdir_addr_t DIR_ADDR [8] = '{`PDIR_DIR_P1, `PDIR_DIR_P3,
    `PDIR_DIR_P4, `PDIR_DIR_P5, `PDIR_DIR_P6, `PDIR_DIR_P7, `PDIR_DIR_P8,
    `PDIR_DIR_PA};

  logic [NPORT*8-1:0] pin_s1_q;
  logic [NPORT*8-1:0] pin_s2_q;
  logic [NPORT-1:0] data_hit;
  logic [NPORT-1:0] dir_hit;
  pdir_pkg::pdir_byte_t port_view [NPORT];
  pdir_pkg::pdir_byte_t latch_q [NPORT];
  pdir_pkg::pdir_byte_t dir_q [NPORT];

  // Pins come from outside the clock domain, so they pass two flip-flops first.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      assign data_hit[g] = (bus_addr == DATA_ADDR[g]);
      assign dir_hit[g] = (bus_addr == DIR_ADDR[g]);

      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          latch_q[g] <= `PDIR_RESET;
        end else if (bus_wr && data_hit[g]) begin
          latch_q[g] <= bus_wdata;
        end
      end

      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          dir_q[g] <= `PDIR_RESET;
        end else if (bus_wr && dir_hit[g]) begin
          dir_q[g] <= bus_wdata;
        end
      end

      // Output bits show the latch, input bits show the synchronised pin.
      assign port_view[g] = (dir_q[g] & latch_q[g]) |
        (~dir_q[g] & pin_s2_q[g*8 +: 8]);
      assign pin_out[g*8 +: 8] = latch_q[g];
      assign pin_oe_n[g*8 +: 8] = ~dir_q[g];
    end
  endgenerate

  // Reads are registered: the answer stands from the edge after the strobe until the next read.
  // A read of a direction address answers all ones, so a read-modify-write of one bit
  // writes ones into every other direction bit; software must work on a shadow copy.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= '0;
    end else if (bus_rd) begin
      bus_rdata <= '0;
      for (int i = 0; i < NPORT; i++) begin
        if (data_hit[i]) begin
          bus_rdata <= port_view[i];
        end
        if (dir_hit[i]) begin
          bus_rdata <= `PDIR_DIR_READ;
        end
      end
    end
  end

  assign bus_hit = (|data_hit) | (|dir_hit);

  // Direction reads answer all ones, whatever was last written.
  a_dir_reads_ones: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_rd && (|dir_hit)) |=> (bus_rdata == 8'hFF))
    else $error("direction read not all ones");
  a_input_oe_off: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 (dir_q[0] == 8'h00) |-> (pin_oe_n[7:0] == 8'hFF))
    else $error("input pin driven");
  a_dir_write_out: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_wr && dir_hit[1]) |=> (pin_oe_n[15:8] == ~$past(bus_wdata)))
    else $error("direction write did not set enables");
  a_data_write_pin: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_wr && data_hit[0]) |=> (pin_out[7:0] == $past(bus_wdata)))
    else $error("latch not on pin");
  a_data_readback: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_rd && data_hit[0]) |=> (bus_rdata ==
      (($past(dir_q[0]) & $past(latch_q[0])) | (~$past(dir_q[0]) & $past(pin_s2_q[7:0])))))
    else $error("data read mix wrong");
  a_data_addr_p1: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_addr == 16'hFFD4) |-> data_hit[0])
    else $error("port 1 data decode");
  a_data_addr_pa: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_addr == 16'hFFDD) |-> data_hit[7])
    else $error("port A data decode");
  a_dir_addr_pa: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_addr == 16'hFFED) |-> dir_hit[7])
    else $error("port A direction decode");
  a_reset_inputs: assert property (@(posedge mclk)
    $rose(nrst) |-> (pin_oe_n == '1))
    else $error("pins not inputs after reset");
  // An address outside the map reads as zero and changes nothing.
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (!nrst)
    (bus_rd && !bus_hit) |=> (bus_rdata == 8'h00))
    else $error("unmapped read not zero");

  // The write and read checks, repeated for every port with hold checks added, so that a decode slip on one port shows up.
  generate
    for (g = 0; g < NPORT; g++) begin : g_chk
      a_port_oe_dir: assert property (@(posedge mclk) disable iff (!nrst)
        (bus_wr && dir_hit[g]) |=> (pin_oe_n[g*8 +: 8] == ~$past(bus_wdata)))
        else $error("port enables do not follow direction write");
      a_port_dir_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !(bus_wr && dir_hit[g]) |=> $stable(pin_oe_n[g*8 +: 8]))
        else $error("port enables changed without direction write");
      a_port_latch_pin: assert property (@(posedge mclk) disable iff (!nrst)
        (bus_wr && data_hit[g]) |=> (pin_out[g*8 +: 8] == $past(bus_wdata)))
        else $error("port pins do not follow latch write");
      a_port_latch_hold: assert property (@(posedge mclk) disable iff (!nrst)
        !(bus_wr && data_hit[g]) |=> $stable(pin_out[g*8 +: 8]))
        else $error("port pins changed without latch write");
      a_port_dir_ones: assert property (@(posedge mclk) disable iff (!nrst)
        (bus_rd && dir_hit[g]) |=> (bus_rdata == 8'hFF))
        else $error("port direction read not all ones");
      a_port_data_read: assert property (@(posedge mclk) disable iff (!nrst)
        (bus_rd && data_hit[g]) |=> (bus_rdata ==
          (($past(dir_q[g]) & $past(latch_q[g])) |
          (~$past(dir_q[g]) & $past(pin_s2_q[g*8 +: 8])))))
        else $error("port data read mix wrong");
    end
  endgenerate

  c_dir_read: cover property (@(posedge mclk) bus_rd && dir_hit[1]);
  c_data_write: cover property (@(posedge mclk) bus_wr && data_hit[1]);
  c_mixed_read: cover property (@(posedge mclk) bus_rd && data_hit[1] && dir_q[1] == 8'h3F);
  c_bit_clear: cover property (@(posedge mclk) bus_wr && dir_hit[1] && bus_wdata == 8'hFE);
  c_reset_release: cover property (@(posedge mclk) $rose(nrst));
endmodule

// [test/pdir_cpu.sv]
/* CPU bus master model for the port register block.
   Assumes the block samples its strobes on the rising edge of mclk. */
`timescale 1ns/1ns
module pdir_cpu (
  input wire logic mclk,
  output pdir_pkg::pdir_addr_t addr,
  output logic wr,
  output logic rd,
  output pdir_pkg::pdir_byte_t wdata,
  input wire pdir_pkg::pdir_byte_t rdata
);
  initial begin
    addr = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 8'h00;
  end
  // One byte move; a released bus shows the inverse of its last value.
  task automatic access(input pdir_pkg::pdir_addr_t a, input logic w,
      input pdir_pkg::pdir_byte_t d, output pdir_pkg::pdir_byte_t q);
    @(negedge mclk);
    addr = a;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
    @(posedge mclk);
    #1 q = rdata;
  endtask
  task automatic bit_op(input pdir_pkg::pdir_addr_t a, input int b, input logic v);
    pdir_pkg::pdir_byte_t q;
    access(a, 1'b0, 8'h00, q);
    q[b] = v;
    access(a, 1'b1, q, q);
  endtask
endmodule

// [test/port_direction_and_data_regs_tb.sv]
/* Self-checking bench for the eight-port direction and data registers.
   Assumes the CPU model drives the bus on falling edges of mclk. */
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: got %h expected %h", $time, a, b); end end
module port_direction_and_data_regs_tb;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  pdir_pkg::pdir_addr_t bus_addr, a;
  logic bus_wr, bus_rd, bus_hit;
  pdir_pkg::pdir_byte_t bus_wdata, bus_rdata, q, d, v, p, s;
  logic [63:0] pin_in = 64'h0, pin_out, pin_oe_n;
  logic [31:0] seed = 32'h9BCA244E;
  logic [7:0] lo [8] = '{8'hD4, 8'hD6, 8'hD7, 8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDD};
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 mclk = ~mclk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic exp_hit(input pdir_pkg::pdir_addr_t ad);
    logic h;
    h = 1'b0;
    for (int j = 0; j < 8; j++) begin
      if (ad == {8'hFF, lo[j]} || ad == {8'hFF, lo[j] + 8'h10}) h = 1'b1;
    end
    return h;
  endfunction
  always @(posedge mclk) if (nrst) `CHK(bus_hit, exp_hit(bus_addr))
  function automatic pdir_pkg::pdir_byte_t exp_rd(input pdir_pkg::pdir_byte_t dd, vv, pp);
    return (dd & vv) | (~dd & pp);
  endfunction
  pdir_ports #(.NPORT(8)) i_pdir_ports (.mclk(mclk), .nrst(nrst), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_hit(bus_hit), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  pdir_cpu i_pdir_cpu (.mclk(mclk), .addr(bus_addr), .wr(bus_wr), .rd(bus_rd),
    .wdata(bus_wdata), .rdata(bus_rdata));
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    `CHK(pin_oe_n, {64{1'b1}})
    `CHK(pin_out, 64'h0)
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      {p, v, d} = seed[23:0];
      if (k == 1) d = 8'h3F;
      a = {8'hFF, lo[k]};
      @(negedge mclk) pin_in[k*8+:8] = p;
      i_pdir_cpu.access(a + 16'h0010, 1'b1, d, q);
      i_pdir_cpu.access(a, 1'b1, v, q);
      `CHK(pin_oe_n[k*8+:8], ~d)
      `CHK(pin_out[k*8+:8], v)
      i_pdir_cpu.access(a + 16'h0010, 1'b0, 8'h00, q);
      `CHK(q, 8'hFF)
      i_pdir_cpu.access(a, 1'b0, 8'h00, q);
      `CHK(q, exp_rd(d, v, p))
    end
    // A bit clear on a write-only byte turns the input pins into outputs.
    i_pdir_cpu.bit_op(16'hFFE6, 0, 1'b0);
    `CHK(pin_oe_n[15:8], 8'h01)
    s = 8'h3F;
    s[0] = 1'b0;
    i_pdir_cpu.access(16'hFFE6, 1'b1, s, q);
    `CHK(pin_oe_n[15:8], ~s)
    i_pdir_cpu.access(16'hFFE5, 1'b0, 8'h00, q);
    `CHK(q, 8'h00)
    @(negedge mclk) nrst = 1'b0;
    @(negedge mclk) `CHK(pin_oe_n, {64{1'b1}})
    `CHK(pin_out, 64'h0)
    nrst = 1'b1;
    complete_run();
  end
endmodule
